/* File: core/pio_port_io.sv */
// How it works
// R1 - Sixteen pins in three ports; P0.0 to P1.6 selectable digital or analog.
// R2 - P2.7 is digital only and shares its pad with the debug data pin.
// R3 - After reset pins are digital, outputs high impedance, weak pull-ups on.
// R4 - Input-mode bit 0 makes a pin analog: pull-up and receiver off.
// R5 - Analog pins always read back zero.
// R6 - Software should also turn off the output driver of analog pins.
// R7 - Software should not leave digital mode on pins used by analog peripherals.
// R8 - Pins for digital peripherals, event capture or GPIO use input-mode bit 1.
// R9 - Output-mode bit 1 gives push-pull, driving the pad high or low.
// R10 - Output-mode bit 0 gives open-drain: pull low for 0, release for 1.
// R11 - Pull-up on only while undriven; the global disable bit turns all off.
// R12 - The system keeps every digital pin pulled or driven to a valid level; with the global disable bit set, undriven digital pins float.
// R13 - Digital pins read the sampled pad level, not the output latch.
// R14 - Each driver has a per-pin high or low strength, low after reset.
// R15 - For analog use software sets open-drain, latch one and skip one.
// R16 - Crossbar may use only P0.0 to P1.6 pins whose skip bit is zero.
// R17 - With the crossbar disabled all output drivers are held off, except P2.7 while the debug data pin owns it.
// R18 - Each configuration register holds one bit per pin, bit n for pin n.
`timescale 1ns/1ps

module pio_port_io
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // AXI4-Lite write channels.
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels.
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Pad cells.
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_in,
    output logic [pio_pkg::PIO_PINS-1:0] pad_out,
    output logic [pio_pkg::PIO_PINS-1:0] pad_oe_out,
    output logic [pio_pkg::PIO_PINS-1:0] pad_pullup_out,
    output logic [pio_pkg::PIO_PINS-1:0] pad_drive_high_out,
    output logic [pio_pkg::PIO_PINS-1:0] pad_rx_en_out,
    // Crossbar side.
    input wire logic [pio_pkg::PIO_XBAR_PINS-1:0] xbar_select_in,
    input wire logic [pio_pkg::PIO_XBAR_PINS-1:0] xbar_value_in,
    output logic [pio_pkg::PIO_XBAR_PINS-1:0] xbar_eligible_out,
    // Debug data pin sharing.
    input wire logic debug_active_in,
    input wire logic debug_data_in,
    input wire logic debug_data_oe_in,
    output logic debug_data_pin_out
);
    import pio_pkg::*;

    // Refuse address widths that the decoder cannot serve.
    if (ADDR_W < PIO_DEC_BITS || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 8 and 32.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic int pin_flat(input int pin);
        pin_flat = (pin == PIO_DEBUG_PIN) ? PIO_DEBUG_FLAT : pin;
    endfunction

    function automatic logic [7:0] impl_mask(input logic [1:0] port);
        case (port)
            2'h0: impl_mask = PIO_IMPL_P0;
            2'h1: impl_mask = PIO_IMPL_P1;
            2'h2: impl_mask = PIO_IMPL_P2;
            default: impl_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] cfg_mask(input logic [1:0] port);
        cfg_mask = (port == 2'h2) ? PIO_CFG_P2 : impl_mask(port);
    endfunction

    function automatic pio_grp_e decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] base;
        logic upper_zero;
        base = {addr[7:4], 4'h0};
        upper_zero = (addr >> PIO_DEC_BITS) == '0;
        decode = PIO_GRP_NONE;
        if (upper_zero && addr[1:0] == 2'h0 && addr[3:2] != 2'h3)
        begin
            case (base)
                PIO_OFF_PORT: decode = PIO_GRP_PORT;
                PIO_OFF_INMODE: decode = PIO_GRP_INMODE;
                PIO_OFF_OUTMODE: decode = PIO_GRP_OUTMODE;
                PIO_OFF_SKIP: decode = PIO_GRP_SKIP;
                PIO_OFF_DRIVE: decode = PIO_GRP_DRIVE;
                PIO_OFF_CTRL: decode = (addr[3:2] == 2'h0) ? PIO_GRP_CTRL : PIO_GRP_NONE;
                default: decode = PIO_GRP_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pad input synchroniser and filter.

    logic [PIO_PINS-1:0] sync1;
    logic [PIO_PINS-1:0] sync2;
    logic [PIO_PINS-1:0] sync3;
    logic [PIO_PINS-1:0] pad_level;
    logic [PIO_PINS-1:0] next_pad_level;

    always_comb
    begin
        for (int i = 0; i < PIO_PINS; i++)
        begin
            next_pad_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : pad_level[i];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pad_level <= '0;
        end
        else
        begin
            sync1 <= pad_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pad_level <= next_pad_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers, one bit per pin of each port.

    logic [PIO_PORTS-1:0][7:0] latch;
    logic [PIO_PORTS-1:0][7:0] inmode;
    logic [PIO_PORTS-1:0][7:0] outmode;
    logic [PIO_PORTS-1:0][7:0] skip;
    logic [PIO_PORTS-1:0][7:0] drive;
    logic [1:0] ctrl;
    logic [PIO_PORTS-1:0][7:0] next_latch;
    logic [PIO_PORTS-1:0][7:0] next_inmode;
    logic [PIO_PORTS-1:0][7:0] next_outmode;
    logic [PIO_PORTS-1:0][7:0] next_skip;
    logic [PIO_PORTS-1:0][7:0] next_drive;
    logic [1:0] next_ctrl;
    logic [PIO_FLAT_BITS-1:0] digital_flat;
    logic [PIO_FLAT_BITS-1:0] read_flat;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign digital_flat = inmode;

    // Port reads return the filtered pad level of digital pins only.
    always_comb
    begin
        read_flat = '0;
        for (int i = 0; i < PIO_PINS; i++)
        begin
            read_flat[pin_flat(i)] = pad_level[i] & digital_flat[pin_flat(i)]; // R5 R13
        end
    end

    always_comb
    begin
        logic [1:0] port;
        logic [7:0] wm;
        logic [7:0] cm;
        logic [7:0] wd;
        port = wr_addr[3:2];
        wm = impl_mask(port);
        cm = cfg_mask(port);
        wd = wr_data[7:0];
        next_latch = latch;
        next_inmode = inmode;
        next_outmode = outmode;
        next_skip = skip;
        next_drive = drive;
        next_ctrl = ctrl;
        if (do_write && wr_strb[0])
        begin
            case (decode(wr_addr))
                PIO_GRP_PORT: next_latch[port] = (latch[port] & ~wm) | (wd & wm);
                PIO_GRP_INMODE: next_inmode[port] = (inmode[port] & ~cm) | (wd & cm); // R2 R4 R8 R18
                PIO_GRP_OUTMODE: next_outmode[port] = (outmode[port] & ~wm) | (wd & wm); // R18
                PIO_GRP_SKIP: next_skip[port] = (skip[port] & ~cm) | (wd & cm); // R18
                PIO_GRP_DRIVE: next_drive[port] = (drive[port] & ~wm) | (wd & wm); // R14 R18
                PIO_GRP_CTRL: next_ctrl = wd[1:0];
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            latch <= {PIO_PORTS{PIO_RST_LATCH}};
            inmode <= {PIO_PORTS{PIO_RST_INMODE}}; // R3
            outmode <= {PIO_PORTS{PIO_RST_OUTMODE}};
            skip <= {PIO_PORTS{PIO_RST_SKIP}};
            drive <= {PIO_PORTS{PIO_RST_DRIVE}}; // R14
            ctrl <= PIO_RST_CTRL; // R3
        end
        else
        begin
            latch <= next_latch;
            inmode <= next_inmode;
            outmode <= next_outmode;
            skip <= next_skip;
            drive <= next_drive;
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad cell control.

    logic [PIO_PINS-1:0] next_pad_out;
    logic [PIO_PINS-1:0] next_pad_oe;
    logic [PIO_PINS-1:0] next_pullup;
    logic [PIO_PINS-1:0] next_drive_high;
    logic [PIO_PINS-1:0] next_rx_en;
    logic [PIO_XBAR_PINS-1:0] next_eligible;

    always_comb
    begin
        logic value;
        logic push;
        logic enable;
        int f;
        value = 1'b0;
        push = 1'b0;
        enable = 1'b0;
        f = 0;
        for (int i = 0; i < PIO_PINS; i++)
        begin
            f = pin_flat(i);
            push = outmode[f / 8][f % 8];
            enable = ctrl[PIO_CTRL_XBAR_BIT]; // R17
            value = latch[f / 8][f % 8];
            if (i < PIO_XBAR_PINS)
            begin
                next_eligible[i] = ~skip[f / 8][f % 8]; // R16
                if (xbar_select_in[i] && !skip[f / 8][f % 8])
                begin
                    value = xbar_value_in[i]; // R16
                end
            end
            if (i == PIO_DEBUG_PIN && debug_active_in)
            begin
                enable = debug_data_oe_in; // R2
                value = debug_data_in; // R2
                push = 1'b1;
            end
            next_pad_oe[i] = enable & (push | ~value); // R9 R10 R17
            next_pad_out[i] = push & value; // R9 R10
            next_pullup[i] = digital_flat[f] & ~ctrl[PIO_CTRL_PUD_BIT] & ~next_pad_oe[i]; // R3 R4 R11
            next_drive_high[i] = drive[f / 8][f % 8]; // R14
            next_rx_en[i] = digital_flat[f]; // R1 R4
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            pad_out <= '0;
            pad_oe_out <= '0;
            pad_pullup_out <= '1;
            pad_drive_high_out <= '0;
            pad_rx_en_out <= '1;
            xbar_eligible_out <= '1;
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe_out <= next_pad_oe;
            pad_pullup_out <= next_pullup;
            pad_drive_high_out <= next_drive_high;
            pad_rx_en_out <= next_rx_en;
            xbar_eligible_out <= next_eligible;
        end
    end

    assign debug_data_pin_out = pad_level[PIO_DEBUG_PIN];

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;

    assign s_axi_awready_out = ~aw_held;
    assign s_axi_wready_out = ~w_held;
    assign s_axi_arready_out = ~rvalid;
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rresp_out = rresp;
    assign s_axi_rdata_out = rdata;
    assign do_write = aw_held & w_held & ~bvalid;
    assign wr_addr = aw_addr;
    assign wr_data = w_data;
    assign wr_strb = w_strb;

    always_comb
    begin
        logic [1:0] port;
        logic [7:0] rd;
        port = s_axi_araddr_in[3:2];
        rd = 8'h00;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid_in && !aw_held)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_held)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (decode(aw_addr) == PIO_GRP_NONE) ? PIO_RESP_SLVERR : PIO_RESP_OKAY;
        end
        else if (bvalid && s_axi_bready_in)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !rvalid)
        begin
            case (decode(s_axi_araddr_in))
                PIO_GRP_PORT: rd = read_flat[port * 8 +: 8];
                PIO_GRP_INMODE: rd = inmode[port] & impl_mask(port);
                PIO_GRP_OUTMODE: rd = outmode[port] & impl_mask(port);
                PIO_GRP_SKIP: rd = skip[port] & cfg_mask(port);
                PIO_GRP_DRIVE: rd = drive[port] & impl_mask(port);
                PIO_GRP_CTRL: rd = {6'h00, ctrl};
                default: rd = 8'h00;
            endcase
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, rd};
            next_rresp = (decode(s_axi_araddr_in) == PIO_GRP_NONE) ? PIO_RESP_SLVERR : PIO_RESP_OKAY;
        end
        else if (rvalid && s_axi_rready_in)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= PIO_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= PIO_RESP_OKAY;
            rdata <= 32'h00000000;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

endmodule

/* File: core/pio_pkg.sv */
package pio_pkg;

    // Pin and port layout.
    localparam int PIO_PORTS = 3;
    localparam int PIO_PINS = 16;
    localparam int PIO_XBAR_PINS = 15;
    localparam int PIO_FLAT_BITS = 24;
    localparam int PIO_DEBUG_PIN = 15;
    localparam int PIO_DEBUG_FLAT = 23;
    localparam int PIO_DEC_BITS = 8;

    // Register byte offsets; each group but the control word holds one word per port.
    localparam logic [7:0] PIO_OFF_PORT = 8'h00;
    localparam logic [7:0] PIO_OFF_INMODE = 8'h10;
    localparam logic [7:0] PIO_OFF_OUTMODE = 8'h20;
    localparam logic [7:0] PIO_OFF_SKIP = 8'h30;
    localparam logic [7:0] PIO_OFF_DRIVE = 8'h40;
    localparam logic [7:0] PIO_OFF_CTRL = 8'h50;

    // Implemented and writable bits per port.
    localparam logic [7:0] PIO_IMPL_P0 = 8'hff;
    localparam logic [7:0] PIO_IMPL_P1 = 8'h7f;
    localparam logic [7:0] PIO_IMPL_P2 = 8'h80;
    localparam logic [7:0] PIO_CFG_P2 = 8'h00;

    // Reset values.
    localparam logic [7:0] PIO_RST_LATCH = 8'hff;
    localparam logic [7:0] PIO_RST_INMODE = 8'hff;
    localparam logic [7:0] PIO_RST_OUTMODE = 8'h00;
    localparam logic [7:0] PIO_RST_SKIP = 8'h00;
    localparam logic [7:0] PIO_RST_DRIVE = 8'h00;
    localparam logic [1:0] PIO_RST_CTRL = 2'h0;

    // Control word fields.
    localparam int PIO_CTRL_XBAR_BIT = 0;
    localparam int PIO_CTRL_PUD_BIT = 1;

    // Bus responses.
    localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

    typedef enum {PIO_GRP_PORT, PIO_GRP_INMODE, PIO_GRP_OUTMODE, PIO_GRP_SKIP,
                  PIO_GRP_DRIVE, PIO_GRP_CTRL, PIO_GRP_NONE} pio_grp_e;

endpackage

/* File: verification/pio_pad_model.sv */
`timescale 1ns/1ps
module pio_pad_model
(
    // Clock.
    input wire logic clk_sys_in,
    // Device pad cell.
    input wire logic [pio_pkg::PIO_PINS-1:0] drv_val_in,
    input wire logic [pio_pkg::PIO_PINS-1:0] drv_oe_in,
    input wire logic [pio_pkg::PIO_PINS-1:0] pull_in,
    // Outside logic.
    input wire logic [pio_pkg::PIO_PINS-1:0] ext_val_in,
    input wire logic [pio_pkg::PIO_PINS-1:0] ext_oe_in,
    // Resolved pad level.
    output logic [pio_pkg::PIO_PINS-1:0] pad_level_out
);
    import pio_pkg::*;
    logic [PIO_PINS-1:0] float_q = '0;
    // An undriven pad without pull-up wanders every cycle.
    always @(posedge clk_sys_in)
        float_q <= ~float_q;
    assign pad_level_out = (drv_oe_in & drv_val_in) | (~drv_oe_in & ext_oe_in & ext_val_in)
        | (~drv_oe_in & ~ext_oe_in & (pull_in | float_q));
endmodule

/* File: verification/pio_port_io_props.sv */
`timescale 1ns/1ps
module pio_port_io_props
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Bus handshakes.
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Pads.
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_in,
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_out,
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_oe_out,
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_pullup_out,
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_drive_high_out,
    input wire logic [pio_pkg::PIO_PINS-1:0] pad_rx_en_out,
    input wire logic [pio_pkg::PIO_XBAR_PINS-1:0] xbar_eligible_out,
    // Debug pin.
    input wire logic debug_active_in,
    input wire logic debug_data_in,
    input wire logic debug_data_oe_in,
    input wire logic debug_data_pin_out
);
    import pio_pkg::*;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    chk_reset_pads: assert property (disable iff (1'b0) rst_in |=> pad_oe_out == '0 && &pad_pullup_out
        && &pad_rx_en_out && pad_drive_high_out == '0 && &xbar_eligible_out)
        else $error("pads not in reset state");
    chk_pull_drive: assert property ((pad_pullup_out & pad_oe_out) == '0)
        else $error("pull-up on while driving");
    chk_pull_analog: assert property ((pad_pullup_out & ~pad_rx_en_out) == '0)
        else $error("pull-up on for analog pin");
    chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out && !s_axi_bvalid_out |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data late");
    chk_read_release: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("read data not released after ready");
    chk_debug_own: assert property (debug_active_in |=> pad_oe_out[PIO_DEBUG_PIN] == $past(debug_data_oe_in)
        && (!pad_oe_out[PIO_DEBUG_PIN] || pad_out[PIO_DEBUG_PIN] == $past(debug_data_in)))
        else $error("debug data pin not driven as asked");
    chk_debug_level: assert property ($stable(pad_in[PIO_DEBUG_PIN])[*6]
        |-> debug_data_pin_out == pad_in[PIO_DEBUG_PIN])
        else $error("debug data pin level wrong");
endmodule

bind pio_port_io pio_port_io_props u_props (.*);

/* File: verification/pio_port_io_tb.sv */
`timescale 1ns/1ps
module pio_port_io_tb;
    import pio_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} pio_row_s;
    logic clk_sys_in = 1'h0;
    logic rst_in = 1'h1;
    logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, q;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic [15:0] pad_in, pad_out, pad_oe_out, pad_pullup_out, pad_drive_high_out, pad_rx_en_out;
    logic [15:0] ext_val = 16'h0, ext_oe = 16'h0;
    logic [14:0] xbar_select_in = 15'h0, xbar_value_in = 15'h0, xbar_eligible_out;
    logic debug_active_in = 1'h0, debug_data_in = 1'h0, debug_data_oe_in = 1'h0, debug_data_pin_out;
    int n_fail = 0, n_tests = 0;
    pio_row_s rows [13];

    always #2.5 clk_sys_in = ~clk_sys_in;

    pio_port_io #(.ADDR_W(8)) uut (.*);
    pio_pad_model pm (.clk_sys_in(clk_sys_in), .drv_val_in(pad_out), .drv_oe_in(pad_oe_out),
        .pull_in(pad_pullup_out), .ext_val_in(ext_val), .ext_oe_in(ext_oe), .pad_level_out(pad_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; each valid is held until its handshake edge, ready until the answering edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] dq, output logic [1:0] rq);
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_araddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= w;
        s_axi_wvalid_in <= w;
        s_axi_bready_in <= w;
        s_axi_arvalid_in <= !w;
        s_axi_rready_in <= !w;
        rq = 2'h3;
        dq = 32'h0;
        while (rq === 2'h3)
        begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'h0;
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'h0;
            if (w ? s_axi_bvalid_out : s_axi_rvalid_out)
            begin
                rq = w ? s_axi_bresp_out : s_axi_rresp_out;
                dq = s_axi_rdata_out;
                s_axi_bready_in <= 1'h0;
                s_axi_rready_in <= 1'h0;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d, q, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0, q, r);
        check(q, e);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic pads(input logic [15:0] oe, input logic [15:0] v);
        @(posedge clk_sys_in);
        ext_oe <= oe;
        ext_val <= v;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        rows = '{'{1'h0, 8'h10, 32'hff, 2'h0}, '{1'h0, 8'h20, 32'h0, 2'h0}, '{1'h0, 8'h30, 32'h0, 2'h0},
            '{1'h0, 8'h40, 32'h0, 2'h0}, '{1'h0, 8'h50, 32'h0, 2'h0}, '{1'h0, 8'h18, 32'h80, 2'h0},
            '{1'h1, 8'h14, 32'hff, 2'h0}, '{1'h0, 8'h14, 32'h7f, 2'h0}, '{1'h1, 8'h60, 32'h0, 2'h2},
            '{1'h0, 8'h60, 32'h0, 2'h2}, '{1'h1, 8'h12, 32'h0, 2'h2}, '{1'h0, 8'h04, 32'h7f, 2'h0},
            '{1'h0, 8'h08, 32'h80, 2'h0}};
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        settle(1);
        check({16'h0, pad_oe_out}, 32'h0);
        check({16'h0, pad_pullup_out & pad_rx_en_out}, 32'hffff);
        check({16'h0, pad_drive_high_out}, 32'h0);
        check({17'h0, xbar_eligible_out}, 32'h7fff);
        settle(8);
        foreach (rows[i])
        begin
            xfer(rows[i].w, rows[i].a, rows[i].d, q, r);
            check(32'(r), 32'(rows[i].r));
            if (!rows[i].w)
                check(q, rows[i].d);
        end
        pads(16'h00ff, 16'h005a);
        settle(6);
        rd(8'h00, 32'h5a);
        wr(8'h10, 32'h0f);
        settle(2);
        check({16'h0, pad_rx_en_out}, 32'hff0f);
        check({16'h0, pad_pullup_out}, 32'hff0f);
        rd(8'h00, 32'h0a);
        wr(8'h30, 32'hf0);
        settle(2);
        check({17'h0, xbar_eligible_out}, 32'h7f0f);
        wr(8'h10, 32'hff);
        pads(16'h0, 16'h0);
        wr(8'h20, 32'hff);
        wr(8'h00, 32'h00);
        settle(2);
        check({16'h0, pad_oe_out}, 32'h0);
        wr(8'h50, 32'h1);
        settle(2);
        check({pad_oe_out, pad_out}, 32'h00ff_0000);
        check({16'h0, pad_pullup_out}, 32'hff00);
        wr(8'h00, 32'ha5);
        settle(2);
        check({pad_oe_out, pad_out}, 32'h00ff_00a5);
        wr(8'h20, 32'h00);
        settle(6);
        check({pad_oe_out, pad_out}, 32'h005a_0000);
        check({16'h0, pad_pullup_out}, 32'hffa5);
        rd(8'h00, 32'ha5);
        wr(8'h50, 32'h3);
        settle(2);
        check({16'h0, pad_pullup_out}, 32'h0);
        wr(8'h50, 32'h1);
        wr(8'h44, 32'h7f);
        settle(2);
        check({16'h0, pad_drive_high_out}, 32'h7f00);
        @(posedge clk_sys_in);
        xbar_select_in <= 15'h21;
        settle(2);
        check({16'h0, pad_oe_out}, 32'h005b);
        @(posedge clk_sys_in);
        debug_active_in <= 1'h1;
        debug_data_oe_in <= 1'h1;
        debug_data_in <= 1'h1;
        settle(2);
        check(32'({pad_oe_out[15], pad_out[15]}), 32'h3);
        @(posedge clk_sys_in);
        debug_data_oe_in <= 1'h0;
        pads(16'h8000, 16'h0);
        settle(8);
        check(32'(debug_data_pin_out), 32'h0);
        @(posedge clk_sys_in);
        s_axi_wstrb_in <= 4'he;
        wr(8'h14, 32'h00);
        s_axi_wstrb_in <= 4'hf;
        rd(8'h14, 32'h7f);
        @(posedge clk_sys_in);
        rst_in <= 1'h1;
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        rd(8'h10, 32'hff);
        rd(8'h50, 32'h0);
        print_verdict();
    end
endmodule
